//--- design/lfh_pkg.sv
// constants, types and register map of the load-side feedback homing block
package lfh_pkg;
  localparam int unsigned LFH_AW      = 8;
  // register byte addresses
  localparam logic [7:0]  LFH_A_CTRL  = 8'h00;
  localparam logic [7:0]  LFH_A_FILT  = 8'h04;
  localparam logic [7:0]  LFH_A_NUMA  = 8'h08;
  localparam logic [7:0]  LFH_A_DENA  = 8'h0c;
  localparam logic [7:0]  LFH_A_NUMB  = 8'h10;
  localparam logic [7:0]  LFH_A_DENB  = 8'h14;
  localparam logic [7:0]  LFH_A_PPR   = 8'h18;
  localparam logic [7:0]  LFH_A_CMD   = 8'h1c;
  localparam logic [7:0]  LFH_A_LCUM  = 8'h20;
  localparam logic [7:0]  LFH_A_LINFO = 8'h24;
  localparam logic [7:0]  LFH_A_MBEF  = 8'h28;
  localparam logic [7:0]  LFH_A_MAFT  = 8'h2c;
  localparam logic [7:0]  LFH_A_FB    = 8'h30;
  localparam logic [7:0]  LFH_A_HOME  = 8'h34;
  localparam logic [7:0]  LFH_A_STAT  = 8'h38;
  localparam logic [7:0]  LFH_A_MASK  = 8'h3c;
  localparam logic [7:0]  LFH_A_MODE  = 8'h40;
  // control register fields
  localparam int unsigned LFH_C_FULL  = 0;
  localparam int unsigned LFH_C_POL   = 1;
  localparam int unsigned LFH_C_ENC   = 2;
  localparam int unsigned LFH_C_HCS   = 4;
  localparam int unsigned LFH_C_W     = 5;
  // command register bits
  localparam int unsigned LFH_K_DOG   = 0;
  localparam int unsigned LFH_K_DSET  = 1;
  localparam int unsigned LFH_K_ABORT = 2;
  // status and mask bits
  localparam int unsigned LFH_S_REF   = 0;
  localparam int unsigned LFH_S_DONE  = 1;
  localparam int unsigned LFH_S_ERR   = 2;
  localparam int unsigned LFH_S_W     = 3;
  // encoder type codes
  localparam logic [1:0]  LFH_ENC_ABS = 2'h0;
  localparam logic [1:0]  LFH_ENC_INC = 2'h1;
  localparam logic [1:0]  LFH_ENC_ROT = 2'h2;
  // reset values and limits
  localparam logic [12:0] LFH_FILT_RST  = 13'h000a;
  localparam logic [12:0] LFH_FILT_FULL = 13'h1194;
  localparam logic [15:0] LFH_GEAR_RST  = 16'h0001;
  localparam logic [31:0] LFH_PPR_RST   = 32'h0000_1000;
  localparam int unsigned LFH_FILT_SH   = 13;
  typedef enum logic [1:0] {LFH_SEMI, LFH_DUAL, LFH_FULL} lfh_mode_t;
  typedef enum logic [1:0] {LFH_H_IDLE, LFH_H_DOG, LFH_H_GRID} lfh_home_t;
endpackage : lfh_pkg

//--- design/lfh_gear.sv
// fractional scaler turning motor pulses into load-unit pulses
`timescale 1ns/100ps
module lfh_gear #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  // gear ratio
  input  wire logic [W-1:0] num_i,
  input  wire logic [W-1:0] den_i,
  // motor pulses in
  input  wire logic         step_i,
  input  wire logic         up_i,
  // scaled pulses out
  output logic              step_o,
  output logic              up_o
);
  import lfh_pkg::*;

  logic signed [W+1:0] acc_q, acc_d, add, sub, dens;
  logic                fire, fup;

  // one output pulse per cycle at most; a ratio above one lags fast input
  always_comb begin
    dens = $signed({2'b00, den_i});
    add  = '0;
    sub  = '0;
    fire = 1'b0;
    fup  = 1'b0;
    if (step_i) begin
      add = up_i ? $signed({2'b00, num_i}) : -$signed({2'b00, num_i});
    end
    if (den_i != '0 && acc_q >= dens) begin
      sub  = dens;
      fire = 1'b1;
      fup  = 1'b1;
    end else if (den_i != '0 && acc_q <= -dens) begin
      sub  = -dens;
      fire = 1'b1;
    end
    acc_d = acc_q + add - sub;
  end

  // residue and pulse registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      acc_q  <= '0;
      step_o <= 1'b0;
      up_o   <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      step_o <= fire;
      up_o   <= fup;
    end
  end

  property p_gear_fire;
    @(posedge clock_i) disable iff (sys_rst_i)
      (den_i != '0 && acc_q >= dens) |=> (step_o && up_o);
  endproperty
  a_gear_fire: assert property (p_gear_fire)
    else $error("gear residue over one step gave no pulse");
endmodule : lfh_gear

//--- design/lfh_top.sv
// load-side feedback counting, dual feedback blend and homing
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
module lfh_top (
  // clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       sys_rst_i,
  // register port
  input  wire logic [lfh_pkg::LFH_AW-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rdata_o,
  // load-side encoder
  input  wire logic                       ld_step_i,
  input  wire logic                       ld_dir_i,
  input  wire logic                       ld_ref_i,
  input  wire logic                       ld_abs_zero_i,
  // motor encoder
  input  wire logic                       mot_step_i,
  input  wire logic                       mot_dir_i,
  // proximity dog
  input  wire logic                       dog_i,
  // feedback and status
  output logic      [31:0]                fb_pos_o,
  output logic      [1:0]                 ctrl_mode_o,
  output logic                            home_valid_o,
  output logic                            irq_o
);
  import lfh_pkg::*;

  logic [LFH_C_W-1:0] ctrl_q;
  logic [12:0]        filt_q;
  logic [15:0]        num_a_q, den_a_q, num_b_q, den_b_q;
  logic [31:0]        ppr_q, ld_cum_q, ld_cum_d, ld_info_q, ph_q;
  logic [31:0]        mot_bef_q, mot_aft_q, home_pos_q, lp_q, err;
  logic [LFH_S_W-1:0] stat_q, mask_q, ev;
  logic signed [45:0] prod;
  logic               full, ld_up, ref_pass, grid_hit, grid_base, home_hit;
  logic               dog_q, dog_fall, ref_seen_q, ref_ever_q;
  logic               cmd_dog, cmd_dset, cmd_abort, dset_ok, ev_err, ev_home;
  logic               g_step, g_up;
  logic [1:0]         enc;
  logic [31:0]        rd_d;
  lfh_mode_t          mode_d;
  lfh_home_t          hs_q;

  assign full  = ctrl_q[LFH_C_FULL];
  assign enc   = ctrl_q[LFH_C_ENC +: 2];
  assign ld_up = ld_dir_i ^ ctrl_q[LFH_C_POL];
  assign ref_pass = full && ld_ref_i;

  // software settings; filter writes above the full value saturate
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q  <= '0;
      filt_q  <= LFH_FILT_RST;
      num_a_q <= LFH_GEAR_RST;
      den_a_q <= LFH_GEAR_RST;
      num_b_q <= LFH_GEAR_RST;
      den_b_q <= LFH_GEAR_RST;
      ppr_q   <= LFH_PPR_RST;
      mask_q  <= '0;
    end else if (wr_i) begin
      case (addr_i)
        LFH_A_CTRL: ctrl_q <= wdata_i[LFH_C_W-1:0];
        LFH_A_FILT: begin
          if (wdata_i > {19'h0, LFH_FILT_FULL}) filt_q <= LFH_FILT_FULL;
          else filt_q <= wdata_i[12:0];
        end
        LFH_A_NUMA: num_a_q <= wdata_i[15:0];
        LFH_A_DENA: den_a_q <= wdata_i[15:0];
        LFH_A_NUMB: num_b_q <= wdata_i[15:0];
        LFH_A_DENB: den_b_q <= wdata_i[15:0];
        LFH_A_PPR:  ppr_q   <= wdata_i;
        LFH_A_MASK: mask_q  <= wdata_i[LFH_S_W-1:0];
        default: ;
      endcase
    end
  end

  // dog and data-set command strobes only count in fully closed operation; abort counts in any operation
  always_comb begin
    cmd_dog   = wr_i && addr_i == LFH_A_CMD && full && wdata_i[LFH_K_DOG];
    cmd_dset  = wr_i && addr_i == LFH_A_CMD && full && wdata_i[LFH_K_DSET];
    cmd_abort = wr_i && addr_i == LFH_A_CMD && wdata_i[LFH_K_ABORT];
  end

  // control mode from operation mode and filter setting
  always_comb begin
    if (!full || filt_q == '0) mode_d = LFH_SEMI;
    else if (filt_q >= LFH_FILT_FULL) mode_d = LFH_FULL;
    else mode_d = LFH_DUAL;
  end

  // load-side cumulative count
  always_comb begin
    ld_cum_d = ld_cum_q;
    if (full && ld_step_i) begin
      ld_cum_d = ld_up ? ld_cum_q + 32'h1 : ld_cum_q - 32'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) ld_cum_q <= '0;
    else ld_cum_q <= ld_cum_d;
  end

  // load-side position information, zeroed at the reference mark
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) ld_info_q <= '0;
    else if (ref_pass) ld_info_q <= '0;
    else if (full && ld_step_i) begin
      ld_info_q <= ld_up ? ld_info_q + 32'h1 : ld_info_q - 32'h1;
    end
  end

  // motor-side counts before and after the feedback gear
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mot_bef_q <= '0;
      mot_aft_q <= '0;
    end else begin
      if (mot_step_i) begin
        mot_bef_q <= mot_dir_i ? mot_bef_q + 32'h1 : mot_bef_q - 32'h1;
      end
      if (g_step) begin
        mot_aft_q <= g_up ? mot_aft_q + 32'h1 : mot_aft_q - 32'h1;
      end
    end
  end

  lfh_gear #(
    .W (32)
  ) u_gear (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .num_i     (32'(num_a_q * num_b_q)),
    .den_i     (32'(den_a_q * den_b_q)),
    .step_i    (mot_step_i),
    .up_i      (mot_dir_i),
    .step_o    (g_step),
    .up_o      (g_up)
  );

  // grid: load pulses per motor revolution, based on the reference point
  always_comb begin
    grid_hit = full && ld_step_i &&
               (ld_up ? (ph_q + 32'h1 >= ppr_q) : (ph_q == 32'h1));
    if (enc == LFH_ENC_ABS) grid_base = full && ld_abs_zero_i;
    else grid_base = ref_pass && hs_q == LFH_H_DOG && !ref_seen_q;
    // motor Z-phase has no input at all, homing sees load data only
    if (enc == LFH_ENC_ROT) home_hit = ref_pass;
    else home_hit = grid_hit;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) ph_q <= '0;
    else if (grid_base) ph_q <= '0;
    else if (full && ld_step_i) begin
      if (ld_up) ph_q <= (ph_q + 32'h1 >= ppr_q) ? 32'h0 : ph_q + 32'h1;
      else ph_q <= (ph_q == 32'h0) ? ppr_q - 32'h1 : ph_q - 32'h1;
    end
  end

  // dog edge and reference history
  assign dog_fall = dog_q && !dog_i;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dog_q      <= 1'b0;
      ref_ever_q <= 1'b0;
    end else begin
      dog_q <= dog_i;
      if (ref_pass) ref_ever_q <= 1'b1;
    end
  end

  // home events
  always_comb begin
    dset_ok = cmd_dset && hs_q == LFH_H_IDLE &&
              (ref_ever_q || ctrl_q[LFH_C_HCS]);
    ev_err  = (hs_q == LFH_H_DOG && !cmd_abort && dog_fall &&
               !(ref_seen_q || ref_pass)) ||
              (cmd_dset && hs_q == LFH_H_IDLE && !dset_ok);
    ev_home = (hs_q == LFH_H_GRID && !cmd_abort && home_hit) || dset_ok;
    ev      = '0;
    ev[LFH_S_REF]  = ref_pass;
    ev[LFH_S_DONE] = ev_home;
    ev[LFH_S_ERR]  = ev_err;
  end

  // dog return sequence: wait dog off, then the next grid point, or the next mark on a rotary encoder
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      hs_q       <= LFH_H_IDLE;
      ref_seen_q <= 1'b0;
    end else begin
      unique case (hs_q)
        LFH_H_IDLE: begin
          if (cmd_dog) begin
            hs_q       <= LFH_H_DOG;
            ref_seen_q <= (enc == LFH_ENC_ABS);
          end
        end
        LFH_H_DOG: begin
          if (ref_pass) ref_seen_q <= 1'b1;
          if (cmd_abort) hs_q <= LFH_H_IDLE;
          else if (dog_fall) begin
            hs_q <= (ref_seen_q || ref_pass) ? LFH_H_GRID : LFH_H_IDLE;
          end
        end
        LFH_H_GRID: begin
          if (cmd_abort || home_hit) hs_q <= LFH_H_IDLE;
        end
        default: hs_q <= LFH_H_IDLE;
      endcase
    end
  end

  // home position capture; a new dog return drops the old home
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      home_pos_q   <= '0;
      home_valid_o <= 1'b0;
    end else if (ev_home) begin
      home_pos_q   <= ld_cum_d;
      home_valid_o <= 1'b1;
    end else if (cmd_dog && hs_q == LFH_H_IDLE) begin
      home_valid_o <= 1'b0;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      stat_q <= '0;
      irq_o  <= 1'b0;
    end else begin
      if (wr_i && addr_i == LFH_A_STAT) begin
        stat_q <= (stat_q & ~wdata_i[LFH_S_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      irq_o <= |(stat_q & mask_q);
    end
  end

  // dual feedback: low-pass the load-motor gap, gain is filter/8192
  assign err  = ld_cum_q - mot_aft_q - lp_q;
  assign prod = $signed(err) * $signed({1'b0, filt_q});
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lp_q        <= '0;
      fb_pos_o    <= '0;
      ctrl_mode_o <= '0;
    end else begin
      ctrl_mode_o <= mode_d;
      // outside dual mode the gap is tracked so a switch from full to dual is bumpless
      if (mode_d == LFH_DUAL) begin
        lp_q <= lp_q + 32'(prod[LFH_FILT_SH +: 32]);
      end else begin
        lp_q <= ld_cum_q - mot_aft_q;
      end
      unique case (mode_d)
        LFH_SEMI: fb_pos_o <= full ? mot_aft_q : mot_bef_q;
        LFH_DUAL: fb_pos_o <= mot_aft_q + lp_q;
        LFH_FULL: fb_pos_o <= ld_cum_q;
        default:  fb_pos_o <= ld_cum_q;
      endcase
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    unique case (addr_i)
      LFH_A_CTRL:  rd_d = {27'h0, ctrl_q};
      LFH_A_FILT:  rd_d = {19'h0, filt_q};
      LFH_A_NUMA:  rd_d = {16'h0, num_a_q};
      LFH_A_DENA:  rd_d = {16'h0, den_a_q};
      LFH_A_NUMB:  rd_d = {16'h0, num_b_q};
      LFH_A_DENB:  rd_d = {16'h0, den_b_q};
      LFH_A_PPR:   rd_d = ppr_q;
      LFH_A_CMD:   rd_d = {29'h0, home_valid_o, hs_q};
      LFH_A_LCUM:  rd_d = ld_cum_q;
      LFH_A_LINFO: rd_d = ld_info_q;
      LFH_A_MBEF:  rd_d = mot_bef_q;
      LFH_A_MAFT:  rd_d = mot_aft_q;
      LFH_A_FB:    rd_d = fb_pos_o;
      LFH_A_HOME:  rd_d = home_pos_q;
      LFH_A_STAT:  rd_d = {29'h0, stat_q};
      LFH_A_MASK:  rd_d = {29'h0, mask_q};
      LFH_A_MODE:  rd_d = {30'h0, mode_d};
      default:     rd_d = 32'h0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) rdata_o <= '0;
    else rdata_o <= rd_i ? rd_d : 32'h0;
  end

  property p_ld_count;
    @(posedge clock_i) disable iff (sys_rst_i)
      (full && ld_step_i && ld_up) |=> ld_cum_q == $past(ld_cum_q) + 32'h1;
  endproperty
  a_ld_count: assert property (p_ld_count)
    else $error("load count did not step up");

  property p_info_zero;
    @(posedge clock_i) disable iff (sys_rst_i)
      ref_pass |=> (ld_info_q == 32'h0);
  endproperty
  a_info_zero: assert property (p_info_zero)
    else $error("position information not cleared at reference");

  property p_polarity;
    @(posedge clock_i) disable iff (sys_rst_i)
      (full && ld_step_i && ld_dir_i && ctrl_q[LFH_C_POL])
        |=> ld_cum_q == $past(ld_cum_q) - 32'h1;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("reversed polarity did not count down");

  property p_full_fb;
    @(posedge clock_i) disable iff (sys_rst_i)
      (full && filt_q == LFH_FILT_FULL) |=> fb_pos_o == $past(ld_cum_q);
  endproperty
  a_full_fb: assert property (p_full_fb)
    else $error("fully closed feedback not the load count");

  property p_filt_rst;
    @(posedge clock_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> filt_q == LFH_FILT_RST;
  endproperty
  a_filt_rst: assert property (p_filt_rst)
    else $error("filter setting not at its reset value");

  property p_grid_home;
    @(posedge clock_i) disable iff (sys_rst_i)
      (hs_q == LFH_H_GRID && home_hit && !cmd_abort)
        |=> home_valid_o && hs_q == LFH_H_IDLE && stat_q[LFH_S_DONE];
  endproperty
  a_grid_home: assert property (p_grid_home)
    else $error("grid point after dog off did not set home");

  property p_no_ref_err;
    @(posedge clock_i) disable iff (sys_rst_i)
      (hs_q == LFH_H_DOG && dog_fall && !ref_seen_q && !ref_pass &&
       !cmd_abort) |=> stat_q[LFH_S_ERR] && hs_q == LFH_H_IDLE;
  endproperty
  a_no_ref_err: assert property (p_no_ref_err)
    else $error("return without reference did not fail");

  property p_dset_refuse;
    @(posedge clock_i) disable iff (sys_rst_i)
      (cmd_dset && hs_q == LFH_H_IDLE && !ref_ever_q && !ctrl_q[LFH_C_HCS])
        |=> home_valid_o == $past(home_valid_o) && stat_q[LFH_S_ERR];
  endproperty
  a_dset_refuse: assert property (p_dset_refuse)
    else $error("data-setting home taken without reference");

  property p_semi_idle;
    @(posedge clock_i) disable iff (sys_rst_i)
      (!full && hs_q == LFH_H_IDLE) |=> hs_q == LFH_H_IDLE ##0
        ctrl_mode_o == LFH_SEMI;
  endproperty
  a_semi_idle: assert property (p_semi_idle)
    else $error("homing or non-semi mode in semi closed operation");
endmodule : lfh_top

//--- verification/lfh_enc_model.sv
// load-side and motor encoder pair moving together, with reference mark
`timescale 1ns/100ps
module lfh_enc_model (
  // clock
  input  wire logic        clock_i,
  // move request
  input  wire logic        go_i,
  input  wire logic [15:0] cnt_i,
  input  wire logic        up_i,
  input  wire logic [15:0] ref_at_i,
  output logic             busy_o,
  // encoder lines
  output logic             ld_step_o,
  output logic             ld_dir_o,
  output logic             ld_ref_o,
  output logic             mot_step_o,
  output logic             mot_dir_o
);
  int   left = 0;
  int   idx  = 0;
  logic gap  = 1'b0;

  assign busy_o = (left != 0);

  // quiet lines at start
  initial begin
    ld_step_o  = 1'b0;
    ld_dir_o   = 1'b0;
    ld_ref_o   = 1'b0;
    mot_step_o = 1'b0;
    mot_dir_o  = 1'b0;
  end

  // one count every other cycle; direction lines wander between counts
  // so a design that reads them without a step sees garbage
  always @(posedge clock_i) begin
    ld_step_o  <= 1'b0;
    mot_step_o <= 1'b0;
    ld_ref_o   <= 1'b0;
    ld_dir_o   <= ~ld_dir_o;
    mot_dir_o  <= ~mot_dir_o;
    gap        <= ~gap;
    if (go_i) begin
      left <= cnt_i;
      idx  <= 0;
      gap  <= 1'b0;
    end else if (left != 0) begin
      if (!gap) begin
        ld_step_o  <= 1'b1;
        mot_step_o <= 1'b1;
        ld_dir_o   <= up_i;
        mot_dir_o  <= up_i;
        idx        <= idx + 1;
      end else begin
        // mark passes just after the chosen count
        if (ref_at_i != 16'h0 && idx == int'(ref_at_i))
          ld_ref_o <= 1'b1;
        left <= left - 1;
      end
    end
  end
endmodule : lfh_enc_model

//--- verification/tb_lfh_top.sv
// self-checking bench for the load-side feedback homing block
`timescale 1ns/100ps
module tb_lfh_top;
  import lfh_pkg::*;
  logic        clock_i   = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        dog_i     = 1'b0;
  logic        abs_zero  = 1'b0;
  logic        go        = 1'b0;
  logic        up        = 1'b1;
  logic [15:0] cnt       = 16'h0;
  logic [15:0] ref_at    = 16'h0;
  logic [31:0] rdata_o, fb_pos_o, v;
  logic [1:0]  ctrl_mode_o;
  logic        home_valid_o, irq_o, busy;
  logic        ld_step, ld_dir, ld_ref, mot_step, mot_dir;
  logic [31:0] fv [5] = '{32'h0, 32'h1, 32'h1193, 32'h1194, 32'h1388};
  logic [31:0] md [5] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'h2};
  int          bad_count = 0;
  int          n_checks  = 0;
  int          lcum      = 0;
  int          mcum      = 0;
  int          n;

  // 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  lfh_top i_lfh_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ld_step_i(ld_step), .ld_dir_i(ld_dir),
    .ld_ref_i(ld_ref), .ld_abs_zero_i(abs_zero), .mot_step_i(mot_step),
    .mot_dir_i(mot_dir), .dog_i(dog_i), .fb_pos_o(fb_pos_o),
    .ctrl_mode_o(ctrl_mode_o), .home_valid_o(home_valid_o),
    .irq_o(irq_o));

  lfh_enc_model i_lfh_enc_model (.clock_i(clock_i), .go_i(go),
    .cnt_i(cnt), .up_i(up), .ref_at_i(ref_at), .busy_o(busy),
    .ld_step_o(ld_step), .ld_dir_o(ld_dir), .ld_ref_o(ld_ref),
    .mot_step_o(mot_step), .mot_dir_o(mot_dir));

  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
    chk(nm, v, e);
  endtask : rc

  // ls is how the load count follows the move: +1, -1 or 0
  task automatic move(input int c, input logic u, input int r,
                      input int ls);
    @(posedge clock_i);
    cnt    <= c[15:0];
    up     <= u;
    ref_at <= r[15:0];
    go     <= 1'b1;
    @(posedge clock_i);
    go     <= 1'b0;
    for (int i = 0; i <= 400; i++) begin
      @(posedge clock_i);
      if (busy !== 1'b1) break;
      if (i == 400) begin
        bad_count++;
        conclude();
      end
    end
    repeat (4) @(posedge clock_i);
    mcum += u ? c : -c;
    lcum += ls * (u ? c : -c);
  endtask : move

  task automatic wait_home;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock_i);
      if (home_valid_o === 1'b1) return;
    end
    bad_count++;
    conclude();
  endtask : wait_home

  task automatic reset_dut;
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    lcum = 0;
    mcum = 0;
  endtask : reset_dut

  // main sequence
  initial begin
    n = $urandom(5080);
    reset_dut();
    rc(LFH_A_FILT, 32'ha, "filter_reset");
    rc(LFH_A_NUMA, 32'h1, "gear_reset");
    rc(LFH_A_PPR, 32'h1000, "ppr_reset");
    rc(8'h44, 32'h0, "unmapped");
    // dog return that never meets a mark must fail
    wr(LFH_A_CTRL, 32'h5);
    wr(LFH_A_CMD, 32'h1);
    dog_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    dog_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rc(LFH_A_STAT, 32'h4, "stat_dog_err");
    chk("home_valid", {31'h0, home_valid_o}, 32'h0);
    // data set before any mark is refused, allowed with condition select
    wr(LFH_A_STAT, 32'h7);
    wr(LFH_A_CMD, 32'h2);
    repeat (3) @(posedge clock_i);
    rc(LFH_A_STAT, 32'h4, "stat_dset_err");
    wr(LFH_A_STAT, 32'h7);
    wr(LFH_A_CTRL, 32'h15);
    wr(LFH_A_CMD, 32'h2);
    wait_home();
    chk("home_valid", {31'h0, home_valid_o}, 32'h1);
    // counting, mark clearing the info value, and the interrupt
    wr(LFH_A_STAT, 32'h7);
    wr(LFH_A_CTRL, 32'h5);
    wr(LFH_A_MASK, 32'h7);
    n = $urandom_range(20, 1);
    move(n, 1'b1, n, 1);
    rc(LFH_A_LINFO, 32'h0, "load_info");
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    rc(LFH_A_STAT, 32'h1, "stat_ref");
    wr(LFH_A_MASK, 32'h6);
    repeat (2) @(posedge clock_i);
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    wr(LFH_A_STAT, 32'h1);
    wr(LFH_A_MASK, 32'h7);
    repeat (2) @(posedge clock_i);
    chk("irq_cleared", {31'h0, irq_o}, 32'h0);
    rc(LFH_A_LCUM, 32'(lcum), "load_cum");
    // reversed polarity counts down on an upward move
    wr(LFH_A_CTRL, 32'h7);
    move($urandom_range(20, 1), 1'b1, 0, -1);
    rc(LFH_A_LCUM, 32'(lcum), "load_cum_pol");
    // semi operation ignores load counts, motor keeps counting
    wr(LFH_A_CTRL, 32'h4);
    move($urandom_range(20, 1), 1'($urandom), 0, 0);
    rc(LFH_A_LCUM, 32'(lcum), "load_cum_semi");
    rc(LFH_A_MBEF, 32'(mcum), "motor_before");
    rc(LFH_A_MAFT, 32'(mcum), "motor_after");
    // half ratio: eight counts give four after gearing
    wr(LFH_A_DENA, 32'h2);
    move(8, 1'b1, 0, 0);
    rc(LFH_A_MAFT, 32'(mcum - 4), "motor_geared");
    wr(LFH_A_DENA, 32'h1);
    // filter setting selects the control mode; the values assume a
    // model loop gain above 10000 in the loop they feed
    wr(LFH_A_CTRL, 32'h1);
    foreach (fv[i]) begin
      wr(LFH_A_FILT, fv[i]);
      repeat (2) @(posedge clock_i);
      chk("mode", {30'h0, ctrl_mode_o}, md[i]);
    end
    rc(LFH_A_FILT, 32'h1194, "filter_sat");
    chk("fb_full", fb_pos_o, 32'(lcum));
    wr(LFH_A_CTRL, 32'h0);
    repeat (2) @(posedge clock_i);
    chk("mode_semi", {30'h0, ctrl_mode_o}, 32'h0);
    chk("fb_semi", fb_pos_o, 32'(mcum));
    // rotary dog return homes at the first mark after dog off
    reset_dut();
    wr(LFH_A_CTRL, 32'h9);
    wr(LFH_A_CMD, 32'h1);
    dog_i <= 1'b1;
    move(4, 1'b1, 2, 1);
    dog_i <= 1'b0;
    move(3, 1'b1, 0, 1);
    chk("home_early", {31'h0, home_valid_o}, 32'h0);
    move(4, 1'b1, 2, 1);
    wait_home();
    chk("home_rot", {31'h0, home_valid_o}, 32'h1);
    rc(LFH_A_STAT, 32'h3, "stat_home");
    // absolute grid of four counts, zeroed by the position-zero pulse
    wr(LFH_A_PPR, 32'h4);
    wr(LFH_A_CTRL, 32'h1);
    abs_zero <= 1'b1;
    @(posedge clock_i);
    abs_zero <= 1'b0;
    wr(LFH_A_CMD, 32'h1);
    dog_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    dog_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    move(3, 1'b1, 0, 1);
    chk("home_abs_early", {31'h0, home_valid_o}, 32'h0);
    move(2, 1'b1, 0, 1);
    wait_home();
    rc(LFH_A_HOME, 32'(lcum - 1), "home_abs");
    conclude();
  end
endmodule : tb_lfh_top
